// ===== gsc_pkg.sv
// constants, types and checksum function shared by both ends of the link
// Operation
// - device answers only at address 0x58
// - commands are 16 bits including check field
// - every data word followed by CRC byte
// - written data with bad CRC is discarded
// - idle and accepting after power-up delay
// - device acknowledges each good byte
// - measurement starts at second command byte acknowledge (set-baseline starts at the acknowledge of its last CRC byte instead)
// - busy device refuses addressing with not-acknowledge
// - master waits, then polls read header
// - after measurement, read returns CRC-protected words
// - device stops sending after master not-acknowledge
// - master ends read with not-acknowledge, STOP
// - master may truncate read after any byte
// - each result is readable only once
// - bytes beyond response length read all ones
// - master reads quality once every second
// - quality answer: carbon dioxide equivalent, then TVOC
// - first 15 s quality reads 400 and 0
// - baseline read: carbon equivalent then TVOC
// - baseline write order TVOC then carbon equivalent
// - master sends start-estimation after every restart
// - command codes 2003, 2008, 2015, 201E
// - device ready within 0.6 ms
package gsc_pkg;

	localparam logic [6:0]  GSC_ADDR   = 7'h58;
	localparam logic [15:0] CMD_START  = 16'h2003;
	localparam logic [15:0] CMD_QUAL   = 16'h2008;
	localparam logic [15:0] CMD_GETB   = 16'h2015;
	localparam logic [15:0] CMD_SETB   = 16'h201E;
	localparam logic [7:0]  CRC_POLY   = 8'h31;
	localparam logic [7:0]  CRC_INIT   = 8'hFF;
	localparam logic [15:0] CO2_WARM   = 16'h0190;
	localparam logic [15:0] TVOC_WARM  = 16'h0000;
	localparam logic [2:0]  RES_LEN    = 3'h6;
	localparam logic [3:0]  WR_LEN     = 4'h3;
	localparam logic [3:0]  WRB_LEN    = 4'h9;
	localparam logic [3:0]  RD_LEN     = 4'h7;

	// host operation select
	localparam logic [1:0]  OP_START   = 2'h0;
	localparam logic [1:0]  OP_QUAL    = 2'h1;
	localparam logic [1:0]  OP_GETB    = 2'h2;
	localparam logic [1:0]  OP_SETB    = 2'h3;

	// timing: clock rate and documented limits in their own units
	localparam int          CLK_MHZ    = 250;
	localparam int          SCL_KHZ    = 400;
	localparam int          PU_US      = 600;
	localparam int          START_MS   = 10;
	localparam int          QUAL_MS    = 12;
	localparam int          BASE_MS    = 10;
	localparam int          POLL_MS    = 10;
	localparam int          WARM_S     = 15;
	localparam int          PU_CYC     = PU_US * CLK_MHZ;
	localparam int          START_CYC  = START_MS * 1000 * CLK_MHZ;
	localparam int          QUAL_CYC   = QUAL_MS * 1000 * CLK_MHZ;
	localparam int          BASE_CYC   = BASE_MS * 1000 * CLK_MHZ;
	localparam int          POLL_CYC   = POLL_MS * 1000 * CLK_MHZ;
	localparam longint      WARM_CYC   = longint'(WARM_S) * 1000000 * CLK_MHZ;
	// quarter of an SCL period, rounded up so the bus never runs fast
	localparam int          QTR_CYC    = (CLK_MHZ * 1000 + SCL_KHZ * 4 - 1)
	                                     / (SCL_KHZ * 4);

	typedef enum logic [2:0] {
		DS_IDLE = 3'h0,
		DS_ADDR = 3'h1,
		DS_RX   = 3'h3,
		DS_ACK  = 3'h2,
		DS_TX   = 3'h6,
		DS_MACK = 3'h7,
		DS_IGN  = 3'h5
	} gsc_dst_t;

	typedef enum logic [2:0] {
		HS_IDLE  = 3'h0,
		HS_START = 3'h1,
		HS_BITS  = 3'h3,
		HS_ACK   = 3'h2,
		HS_STOP  = 3'h6,
		HS_WAIT  = 3'h7
	} gsc_hst_t;

	// checksum over one 16-bit word, msb first
	function automatic logic [7:0] crc8(input logic [15:0] w);
		logic [7:0] c;
		c = CRC_INIT;
		for (int i = 15; i >= 0; i--) begin
			c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? CRC_POLY : 8'h00);
		end
		return c;
	endfunction

	// recognised command words
	function automatic logic cmd_known(input logic [15:0] c);
		return (c == CMD_START) || (c == CMD_QUAL) || (c == CMD_GETB)
		    || (c == CMD_SETB);
	endfunction

endpackage

// ===== gsc_if.sv
// open-drain two-wire link joining the host and the device
`timescale 1ns/1ps
interface gsc_if;
	logic scl_m_o;
	logic scl_m_oe;
	logic sda_m_o;
	logic sda_m_oe;
	logic sda_s_o;
	logic sda_s_oe;
	logic scl;
	logic sda;

	// wired-and with pull-ups: a line is low while any enabled driver is low
	assign scl = !(scl_m_oe && !scl_m_o);
	assign sda = !((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o));

	modport dev (input scl, input sda, output sda_s_o, output sda_s_oe);
	modport host (input sda, output scl_m_o, output scl_m_oe,
	              output sda_m_o, output sda_m_oe);
endinterface

// ===== gsc_dev.sv
// device end: two-wire target, command decoder and result store
`timescale 1ns/1ps
module gsc_dev #(
	parameter int PU_CYC    = gsc_pkg::PU_CYC,
	parameter int START_CYC = gsc_pkg::START_CYC,
	parameter int QUAL_CYC  = gsc_pkg::QUAL_CYC,
	parameter int BASE_CYC  = gsc_pkg::BASE_CYC,
	parameter logic [31:0] WARM_CYC = 32'(gsc_pkg::WARM_CYC)
) (
	input  wire logic        CLK_I,
	input  wire logic        RST_N_I,
	gsc_if.dev               BUS,
	input  wire logic [15:0] CO2_I,
	input  wire logic [15:0] TVOC_I,
	output logic             READY_O,
	output logic             BUSY_O,
	output logic             WARM_O,
	output logic [15:0]      BASE_CO2_O,
	output logic [15:0]      BASE_TVOC_O
);
	import gsc_pkg::*;

	gsc_dst_t    st_q;
	logic [2:0]  scl_r_q;
	logic [2:0]  sda_r_q;
	logic [3:0]  cnt_q;
	logic [7:0]  sh_q;
	logic        oe_q;
	logic [3:0]  idx_q;
	logic        rd_q;
	logic        mack_q;
	logic [7:0]  cmd_hi_q;
	logic [15:0] wcmd_q;
	logic [7:0]  pbuf_q [0:5];
	logic [2:0]  rd_idx_q;
	logic [2:0]  cur_len_q;
	logic [31:0] pu_cnt_q;
	logic        ready_q;
	logic        busy_q;
	logic [31:0] mcnt_q;
	logic [15:0] mcmd_q;
	logic [2:0]  res_len_q;
	logic [7:0]  res_q [0:7];
	logic        warm_q;
	logic [31:0] wcnt_q;
	logic [15:0] base_co2_q;
	logic [15:0] base_tvoc_q;

	logic        scl_s, scl_p, sda_s, sda_p;
	logic        start_w, stop_w, rise_w, fall_w, dec_w;
	logic        addr_ok_w, rx_ok_w, ack_w, rd_hdr_w, go_w;
	logic [15:0] cmd_w, go_cmd_w, w0_w, w1_w;
	logic [31:0] go_dur_w;
	logic [7:0]  tx_byte_w;

	// two-stage synchronisers, third stage keeps the previous level
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			scl_r_q <= 3'h7;
			sda_r_q <= 3'h7;
		end else begin
			scl_r_q <= {scl_r_q[1:0], BUS.scl};
			sda_r_q <= {sda_r_q[1:0], BUS.sda};
		end
	end

	// line events seen on the synchronised levels
	assign scl_s   = scl_r_q[1];
	assign scl_p   = scl_r_q[2];
	assign sda_s   = sda_r_q[1];
	assign sda_p   = sda_r_q[2];
	assign start_w = scl_s && scl_p && sda_p && !sda_s;
	assign stop_w  = scl_s && scl_p && !sda_p && sda_s;
	assign rise_w  = scl_s && !scl_p;
	assign fall_w  = !scl_s && scl_p;

	// byte decisions, taken at the fall of the 8th clock
	assign dec_w     = fall_w && (cnt_q == 4'h8)
	                && ((st_q == DS_ADDR) || (st_q == DS_RX));
	assign addr_ok_w = (sh_q[7:1] == GSC_ADDR) && ready_q && !busy_q;
	assign cmd_w     = {cmd_hi_q, sh_q};
	always_comb begin
		rx_ok_w = 1'b0;
		if (idx_q == 4'h0)
			rx_ok_w = 1'b1;
		else if (idx_q == 4'h1)
			rx_ok_w = cmd_known(cmd_w);
		else if (idx_q <= 4'h7 && wcmd_q == CMD_SETB) begin
			rx_ok_w = 1'b1;
			if (idx_q == 4'h4)
				rx_ok_w = crc8({pbuf_q[0], pbuf_q[1]}) == sh_q;
			if (idx_q == 4'h7)
				rx_ok_w = crc8({pbuf_q[3], pbuf_q[4]}) == sh_q;
		end
	end
	assign ack_w    = (st_q == DS_ADDR) ? addr_ok_w : rx_ok_w;
	assign rd_hdr_w = dec_w && (st_q == DS_ADDR) && addr_ok_w && sh_q[0];
	assign go_w     = dec_w && (st_q == DS_RX) && rx_ok_w
	               && (((idx_q == 4'h1) && (cmd_w != CMD_SETB))
	               || (idx_q == 4'h7));
	assign go_cmd_w = (idx_q == 4'h7) ? CMD_SETB : cmd_w;
	assign go_dur_w = (go_cmd_w == CMD_START) ? 32'(START_CYC)
	               : (go_cmd_w == CMD_QUAL) ? 32'(QUAL_CYC) : 32'(BASE_CYC);
	// beyond the stored answer the device returns all ones
	assign tx_byte_w = (rd_idx_q < cur_len_q) ? res_q[rd_idx_q] : 8'hFF;

	// power-up delay before commands are accepted
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			pu_cnt_q <= 32'h0;
			ready_q  <= 1'b0;
		end else if (!ready_q) begin
			if (pu_cnt_q == 32'(PU_CYC - 1))
				ready_q <= 1'b1;
			else
				pu_cnt_q <= pu_cnt_q + 32'h1;
		end
	end

	// bit and byte engine of the target
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			st_q      <= DS_IDLE;
			cnt_q     <= 4'h0;
			sh_q      <= 8'h00;
			oe_q      <= 1'b0;
			idx_q     <= 4'h0;
			rd_q      <= 1'b0;
			mack_q    <= 1'b0;
			cmd_hi_q  <= 8'h00;
			wcmd_q    <= 16'h0000;
			rd_idx_q  <= 3'h0;
			cur_len_q <= 3'h0;
			for (int i = 0; i < 6; i++)
				pbuf_q[i] <= 8'h00;
		end else if (stop_w) begin
			st_q <= DS_IDLE;
			oe_q <= 1'b0;
		end else if (start_w) begin
			st_q  <= DS_ADDR;
			cnt_q <= 4'h0;
			oe_q  <= 1'b0;
		end else begin
			unique case (st_q)
				DS_IDLE, DS_IGN: begin
				end
				DS_ADDR, DS_RX: begin
					if (rise_w && cnt_q < 4'h8) begin
						sh_q  <= {sh_q[6:0], sda_s};
						cnt_q <= cnt_q + 4'h1;
					end else if (dec_w) begin
						if (ack_w) begin
							oe_q <= 1'b1;
							st_q <= DS_ACK;
							if (st_q == DS_ADDR) begin
								rd_q      <= sh_q[0];
								idx_q     <= 4'h0;
								rd_idx_q  <= 3'h0;
								cur_len_q <= res_len_q;
							end else begin
								if (idx_q == 4'h0)
									cmd_hi_q <= sh_q;
								if (idx_q == 4'h1)
									wcmd_q <= cmd_w;
								if (idx_q >= 4'h2)
									pbuf_q[3'(idx_q - 4'h2)] <= sh_q;
								idx_q <= idx_q + 4'h1;
							end
						end else begin
							st_q <= DS_IGN;
						end
					end
				end
				DS_ACK: begin
					if (fall_w) begin
						cnt_q <= 4'h0;
						if (rd_q) begin
							st_q     <= DS_TX;
							sh_q     <= tx_byte_w;
							oe_q     <= !tx_byte_w[7];
							rd_idx_q <= (rd_idx_q == 3'h7) ? 3'h7 : rd_idx_q + 3'h1;
						end else begin
							st_q <= DS_RX;
							oe_q <= 1'b0;
						end
					end
				end
				DS_TX: begin
					if (rise_w)
						cnt_q <= cnt_q + 4'h1;
					else if (fall_w) begin
						if (cnt_q == 4'h8) begin
							oe_q <= 1'b0;
							st_q <= DS_MACK;
						end else begin
							sh_q <= {sh_q[6:0], 1'b0};
							oe_q <= !sh_q[6];
						end
					end
				end
				DS_MACK: begin
					if (rise_w)
						mack_q <= !sda_s;
					else if (fall_w) begin
						cnt_q <= 4'h0;
						if (mack_q) begin
							st_q     <= DS_TX;
							sh_q     <= tx_byte_w;
							oe_q     <= !tx_byte_w[7];
							rd_idx_q <= (rd_idx_q == 3'h7) ? 3'h7 : rd_idx_q + 3'h1;
						end else begin
							st_q <= DS_IGN;
						end
					end
				end
				default: st_q <= DS_IDLE;
			endcase
		end
	end

	// words loaded into the answer store when a measurement ends
	assign w0_w = (mcmd_q == CMD_QUAL) ? (warm_q ? CO2_WARM : CO2_I)
	           : base_co2_q;
	assign w1_w = (mcmd_q == CMD_QUAL) ? (warm_q ? TVOC_WARM : TVOC_I)
	           : base_tvoc_q;

	// measurement timer, baseline store and answer store
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			busy_q      <= 1'b0;
			mcnt_q      <= 32'h0;
			mcmd_q      <= 16'h0000;
			res_len_q   <= 3'h0;
			base_co2_q  <= 16'h0000;
			base_tvoc_q <= 16'h0000;
			for (int i = 0; i < 8; i++)
				res_q[i] <= 8'hFF;
		end else begin
			if (rd_hdr_w)
				res_len_q <= 3'h0;
			if (go_w) begin
				busy_q <= 1'b1;
				mcmd_q <= go_cmd_w;
				mcnt_q <= go_dur_w - 32'h1;
				if (go_cmd_w == CMD_SETB) begin
					base_tvoc_q <= {pbuf_q[0], pbuf_q[1]};
					base_co2_q  <= {pbuf_q[3], pbuf_q[4]};
				end
			end else if (busy_q) begin
				if (mcnt_q == 32'h0) begin
					busy_q <= 1'b0;
					if (mcmd_q == CMD_QUAL || mcmd_q == CMD_GETB) begin
						res_len_q <= RES_LEN;
						res_q[0]  <= w0_w[15:8];
						res_q[1]  <= w0_w[7:0];
						res_q[2]  <= crc8(w0_w);
						res_q[3]  <= w1_w[15:8];
						res_q[4]  <= w1_w[7:0];
						res_q[5]  <= crc8(w1_w);
					end
				end else
					mcnt_q <= mcnt_q - 32'h1;
			end
		end
	end

	// warm-up window opened by the start-estimation command
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			warm_q <= 1'b0;
			wcnt_q <= 32'h0;
		end else if (go_w && go_cmd_w == CMD_START) begin
			warm_q <= 1'b1;
			wcnt_q <= 32'h0;
		end else if (warm_q) begin
			if (wcnt_q == WARM_CYC - 32'h1)
				warm_q <= 1'b0;
			else
				wcnt_q <= wcnt_q + 32'h1;
		end
	end

	assign BUS.sda_s_o  = 1'b0; // open drain: only ever pulls low
	assign BUS.sda_s_oe = oe_q;
	assign READY_O      = ready_q;
	assign BUSY_O       = busy_q;
	assign WARM_O       = warm_q;
	assign BASE_CO2_O   = base_co2_q;
	assign BASE_TVOC_O  = base_tvoc_q;
endmodule

// ===== gsc_host.sv
// host end: two-wire master issuing commands and polling for answers
`timescale 1ns/1ps
module gsc_host #(
	parameter int POLL_CYC = gsc_pkg::POLL_CYC
) (
	input  wire logic        CLK_I,
	input  wire logic        RST_N_I,
	gsc_if.host              BUS,
	input  wire logic        CMD_VALID_I,
	input  wire logic [1:0]  CMD_SEL_I,
	input  wire logic [15:0] SET_TVOC_I,
	input  wire logic [15:0] SET_CO2_I,
	output logic             IDLE_O,
	output logic             DONE_O,
	output logic             NACK_O,
	output logic             CRC_OK_O,
	output logic [15:0]      WORD0_O,
	output logic [15:0]      WORD1_O
);
	import gsc_pkg::*;

	gsc_hst_t    st_q;
	logic [1:0]  sda_r_q;
	logic [7:0]  qcnt_q;
	logic [1:0]  ph_q;
	logic [2:0]  bcnt_q;
	logic [7:0]  sh_q;
	logic [3:0]  bidx_q;
	logic [3:0]  nb_q;
	logic        rd_q;
	logic        need_rd_q;
	logic        nack_q;
	logic        scl_oe_q;
	logic        sda_oe_q;
	logic [31:0] wcnt_q;
	logic [7:0]  wbuf_q [0:8];
	logic [7:0]  rbuf_q [0:5];
	logic        done_q, nack_o_q, crc_ok_q;
	logic        idle_q;
	logic [15:0] word0_q, word1_q;
	logic [15:0] code_w;
	logic        tick_w, tx_w, sda_s;

	// data line passes two flip-flops before use
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I)
			sda_r_q <= 2'h3;
		else
			sda_r_q <= {sda_r_q[0], BUS.sda};
	end
	assign sda_s = sda_r_q[1];

	// quarter-period divider that paces the generated clock
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I || tick_w)
			qcnt_q <= 8'h00;
		else
			qcnt_q <= qcnt_q + 8'h01;
	end
	assign tick_w = qcnt_q == 8'(QTR_CYC - 1);

	assign tx_w   = (bidx_q == 4'h0) || !rd_q;
	assign code_w = (CMD_SEL_I == OP_START) ? CMD_START
	             : (CMD_SEL_I == OP_QUAL) ? CMD_QUAL
	             : (CMD_SEL_I == OP_GETB) ? CMD_GETB : CMD_SETB;

	// transaction sequencer
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			st_q      <= HS_IDLE;
			idle_q    <= 1'b1;
			ph_q      <= 2'h0;
			bcnt_q    <= 3'h0;
			sh_q      <= 8'h00;
			bidx_q    <= 4'h0;
			nb_q      <= 4'h0;
			rd_q      <= 1'b0;
			need_rd_q <= 1'b0;
			nack_q    <= 1'b0;
			scl_oe_q  <= 1'b0;
			sda_oe_q  <= 1'b0;
			wcnt_q    <= 32'h0;
			done_q    <= 1'b0;
			nack_o_q  <= 1'b0;
			crc_ok_q  <= 1'b0;
			word0_q   <= 16'h0000;
			word1_q   <= 16'h0000;
			for (int i = 0; i < 9; i++)
				wbuf_q[i] <= 8'h00;
			for (int i = 0; i < 6; i++)
				rbuf_q[i] <= 8'h00;
		end else begin
			done_q <= 1'b0;
			unique case (st_q)
				HS_IDLE: if (CMD_VALID_I) begin
					wbuf_q[0] <= {GSC_ADDR, 1'b0};
					wbuf_q[1] <= code_w[15:8];
					wbuf_q[2] <= code_w[7:0];
					wbuf_q[3] <= SET_TVOC_I[15:8];
					wbuf_q[4] <= SET_TVOC_I[7:0];
					wbuf_q[5] <= crc8(SET_TVOC_I);
					wbuf_q[6] <= SET_CO2_I[15:8];
					wbuf_q[7] <= SET_CO2_I[7:0];
					wbuf_q[8] <= crc8(SET_CO2_I);
					nb_q      <= (CMD_SEL_I == OP_SETB) ? WRB_LEN : WR_LEN;
					need_rd_q <= (CMD_SEL_I == OP_QUAL) || (CMD_SEL_I == OP_GETB);
					rd_q      <= 1'b0;
					nack_q    <= 1'b0;
					ph_q      <= 2'h0;
					st_q      <= HS_START;
					idle_q    <= 1'b0;
				end
				HS_START: if (tick_w) begin
					ph_q <= ph_q + 2'h1;
					if (ph_q == 2'h0) begin
						sda_oe_q <= 1'b0;
						scl_oe_q <= 1'b0;
					end
					if (ph_q == 2'h1)
						sda_oe_q <= 1'b1;
					if (ph_q == 2'h3) begin
						scl_oe_q <= 1'b1;
						bidx_q   <= 4'h0;
						bcnt_q   <= 3'h0;
						sh_q     <= rd_q ? {GSC_ADDR, 1'b1} : wbuf_q[0];
						st_q     <= HS_BITS;
					end
				end
				HS_BITS: if (tick_w) begin
					ph_q <= ph_q + 2'h1;
					if (ph_q == 2'h0)
						sda_oe_q <= tx_w ? !sh_q[7] : 1'b0;
					if (ph_q == 2'h1)
						scl_oe_q <= 1'b0;
					if (ph_q == 2'h3) begin
						sh_q     <= {sh_q[6:0], sda_s};
						scl_oe_q <= 1'b1;
						bcnt_q   <= bcnt_q + 3'h1;
						if (bcnt_q == 3'h7)
							st_q <= HS_ACK;
					end
				end
				HS_ACK: if (tick_w) begin
					ph_q <= ph_q + 2'h1;
					// acknowledge every read byte but the last
					if (ph_q == 2'h0)
						sda_oe_q <= !tx_w && (bidx_q != nb_q - 4'h1);
					if (ph_q == 2'h1)
						scl_oe_q <= 1'b0;
					if (ph_q == 2'h3) begin
						scl_oe_q <= 1'b1;
						if (!tx_w)
							rbuf_q[3'(bidx_q - 4'h1)] <= sh_q;
						if ((tx_w && sda_s) || (bidx_q == nb_q - 4'h1)) begin
							nack_q <= tx_w && sda_s;
							st_q   <= HS_STOP;
						end else begin
							bidx_q <= bidx_q + 4'h1;
							bcnt_q <= 3'h0;
							sh_q   <= wbuf_q[bidx_q + 4'h1];
							st_q   <= HS_BITS;
						end
					end
				end
				HS_STOP: if (tick_w) begin
					ph_q <= ph_q + 2'h1;
					if (ph_q == 2'h0)
						sda_oe_q <= 1'b1;
					if (ph_q == 2'h1)
						scl_oe_q <= 1'b0;
					if (ph_q == 2'h2)
						sda_oe_q <= 1'b0;
					if (ph_q == 2'h3) begin
						wcnt_q <= 32'h0;
						if (!rd_q && need_rd_q && !nack_q) begin
							rd_q <= 1'b1;
							nb_q <= RD_LEN;
							st_q <= HS_WAIT;
						end else if (rd_q && nack_q && bidx_q == 4'h0) begin
							st_q <= HS_WAIT;
						end else begin
							done_q   <= 1'b1;
							nack_o_q <= nack_q;
							word0_q  <= {rbuf_q[0], rbuf_q[1]};
							word1_q  <= {rbuf_q[3], rbuf_q[4]};
							crc_ok_q <= rd_q && !nack_q
							         && crc8({rbuf_q[0], rbuf_q[1]}) == rbuf_q[2]
							         && crc8({rbuf_q[3], rbuf_q[4]}) == rbuf_q[5];
							st_q     <= HS_IDLE;
							idle_q   <= 1'b1;
						end
					end
				end
				HS_WAIT: begin
					if (wcnt_q == 32'(POLL_CYC - 1)) begin
						nack_q <= 1'b0;
						ph_q   <= 2'h0;
						st_q   <= HS_START;
					end else
						wcnt_q <= wcnt_q + 32'h1;
				end
				default: begin
					st_q   <= HS_IDLE;
					idle_q <= 1'b1;
				end
			endcase
		end
	end

	assign BUS.scl_m_o  = 1'b0;
	assign BUS.sda_m_o  = 1'b0;
	assign BUS.scl_m_oe = scl_oe_q;
	assign BUS.sda_m_oe = sda_oe_q;
	assign IDLE_O       = idle_q;
	assign DONE_O       = done_q;
	assign NACK_O       = nack_o_q;
	assign CRC_OK_O     = crc_ok_q;
	assign WORD0_O      = word0_q;
	assign WORD1_O      = word1_q;
endmodule

// ===== gsc_asserts.sv
// link checker for the two-wire interface between host and device
`timescale 1ns/1ps
module gsc_asserts #(
	parameter int PU_CYC   = 20,
	parameter int WARM_CYC = 200000
) (
	input wire logic CLK_I,
	input wire logic RST_N_I,
	input wire logic scl,
	input wire logic sda,
	input wire logic sda_s_o,
	input wire logic sda_s_oe,
	input wire logic READY_O,
	input wire logic BUSY_O,
	input wire logic WARM_O
);
	logic [31:0] pu_q;
	logic [31:0] busy_q;
	logic [31:0] warm_q;

	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RST_N_I);

	// cycles spent waiting for the device to become ready
	always_ff @(posedge CLK_I) begin
		pu_q <= (!RST_N_I || READY_O) ? 32'h0 : pu_q + 32'h1;
	end

	// cycles of the current measurement
	always_ff @(posedge CLK_I) begin
		busy_q <= (!RST_N_I || !BUSY_O) ? 32'h0 : busy_q + 32'h1;
	end

	// cycles of the warm-up phase
	always_ff @(posedge CLK_I) begin
		warm_q <= (!RST_N_I || !WARM_O) ? 32'h0 : warm_q + 32'h1;
	end

	ready_in_time_a: assert property (
		!READY_O |-> pu_q <= PU_CYC + 2)
		else $error("device not ready in time");
	silent_not_ready_a: assert property (
		!READY_O |-> !sda_s_oe)
		else $error("device drives before ready");
	open_drain_a: assert property (
		sda_s_oe |-> !sda_s_o)
		else $error("device drives data high");
	ack_after_fall_a: assert property (
		$rose(sda_s_oe) |-> !scl && !$past(scl))
		else $error("device takes data line outside clock low");
	hold_scl_high_a: assert property (
		scl && $past(scl) |-> $stable(sda_s_oe))
		else $error("device data changes while clock high");
	busy_refuse_a: assert property (
		busy_q > 32'd1000 |-> !sda_s_oe)
		else $error("device answers while measuring");
	start_on_ack_a: assert property (
		$rose(BUSY_O) |-> ##[0:400] (sda_s_oe && !scl))
		else $error("measurement started without acknowledge");
	warm_span_a: assert property (
		WARM_O |-> warm_q <= WARM_CYC)
		else $error("warm-up phase too long");
	release_stop_a: assert property (
		scl && $rose(sda) |=> !sda_s_oe [*8])
		else $error("device drives after stop");
endmodule

// ===== testbench.sv
// self-checking bench joining host and device over the two-wire link
`timescale 1ns/1ps
module testbench;
	import gsc_pkg::*;
	logic        clk       = 1'b0;
	logic        rst_n     = 1'b0;
	logic        cmd_valid = 1'b0;
	logic [1:0]  cmd_sel   = 2'h0;
	logic [15:0] set_tvoc  = 16'h0000;
	logic [15:0] set_co2   = 16'h0000;
	logic [15:0] co2_in    = 16'h0555;
	logic [15:0] tvoc_in   = 16'h0AAA;
	logic        idle, done, nack, crc_ok, ready, busy, warm;
	logic [15:0] word0, word1, base_co2, base_tvoc;
	logic [8:0]  shift_q   = 9'h000;
	int          nbit      = 0;
	logic [7:0]  bytes[$];
	logic        acks[$];
	int          miscompares = 0;
	int          checks      = 0;

	gsc_if gif();

	// short timings; the quality measurement outlasts the first poll
	gsc_dev #(.PU_CYC(20), .START_CYC(200), .QUAL_CYC(8000),
	          .WARM_CYC(32'h00030D40)) gsc_dev_i (
		.CLK_I(clk), .RST_N_I(rst_n), .BUS(gif),
		.CO2_I(co2_in), .TVOC_I(tvoc_in), .READY_O(ready),
		.BUSY_O(busy), .WARM_O(warm), .BASE_CO2_O(base_co2),
		.BASE_TVOC_O(base_tvoc));

	gsc_host #(.POLL_CYC(300)) gsc_host_i (
		.CLK_I(clk), .RST_N_I(rst_n), .BUS(gif),
		.CMD_VALID_I(cmd_valid), .CMD_SEL_I(cmd_sel),
		.SET_TVOC_I(set_tvoc), .SET_CO2_I(set_co2), .IDLE_O(idle),
		.DONE_O(done), .NACK_O(nack), .CRC_OK_O(crc_ok),
		.WORD0_O(word0), .WORD1_O(word1));

	gsc_asserts gsc_asserts_i (
		.CLK_I(clk), .RST_N_I(rst_n), .scl(gif.scl), .sda(gif.sda),
		.sda_s_o(gif.sda_s_o), .sda_s_oe(gif.sda_s_oe),
		.READY_O(ready), .BUSY_O(busy), .WARM_O(warm));

	// 250 MHz clock
	always #2 clk = ~clk;

	// bus monitor: a start clears the bit count, nine bits make a byte
	always @(negedge gif.sda) begin
		if (gif.scl) begin
			nbit = 0;
		end
	end
	always @(posedge gif.scl) begin
		shift_q = {shift_q[7:0], gif.sda};
		nbit = nbit + 1;
		if (nbit == 9) begin
			bytes.push_back(shift_q[8:1]);
			acks.push_back(shift_q[0]);
			nbit = 0;
		end
	end

	task automatic end_of_test();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [15:0] exp,
	                     input logic [15:0] got);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	// issue one host operation and wait for its completion pulse
	task automatic run_op(input logic [1:0] sel);
		int n;
		bytes.delete();
		acks.delete();
		repeat (2) @(posedge clk);
		cmd_sel   <= sel;
		cmd_valid <= 1'b1;
		@(posedge clk);
		cmd_valid <= 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 100000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 100000) begin
			miscompares++;
			$display("ERROR done expected 1 seen timeout");
			end_of_test();
		end
		check("idle", 16'h0001, {15'h0, idle});
	endtask

	// start-estimation: header and command acknowledged, warm-up begins
	task automatic sc_start();
		run_op(OP_START);
		check("ready", 16'h0001, {15'h0, ready});
		check("write header", 16'h00B0, {8'h0, bytes[0]});
		check("command", 16'h2003, {bytes[1], bytes[2]});
		check("acks", 16'h0000, {13'h0, acks[0], acks[1], acks[2]});
		check("nack flag", 16'h0000, {15'h0, nack});
		check("warm flag", 16'h0001, {15'h0, warm});
	endtask

	// read-quality in warm-up: first poll refused, fixed words returned
	task automatic sc_quality();
		int k;
		run_op(OP_QUAL);
		k = bytes.size() - 7;
		check("command", 16'h2008, {bytes[1], bytes[2]});
		check("poll refused", 16'h01B1, {7'h0, acks[3], bytes[3]});
		check("read header", 16'h00B1, {7'h0, acks[k], bytes[k]});
		check("co2 wire", 16'h0190, {bytes[k+1], bytes[k+2]});
		check("tvoc wire", 16'h0000, {bytes[k+4], bytes[k+5]});
		check("last nack", 16'h0001, {15'h0, acks[k+6]});
		check("co2 word", 16'h0190, word0);
		check("tvoc word", 16'h0000, word1);
		check("crc ok", 16'h0001, {15'h0, crc_ok});
	endtask

	// write-baseline: TVOC word first, both checksums accepted and loaded
	task automatic sc_set_base();
		set_tvoc <= 16'h1234;
		set_co2  <= 16'hABCD;
		run_op(OP_SETB);
		check("command", 16'h201E, {bytes[1], bytes[2]});
		check("tvoc first", 16'h1234, {bytes[3], bytes[4]});
		check("co2 second", 16'hABCD, {bytes[6], bytes[7]});
		check("crc acks", 16'h0000, {14'h0, acks[5], acks[8]});
		check("nack flag", 16'h0000, {15'h0, nack});
		check("base tvoc", 16'h1234, base_tvoc);
		check("base co2", 16'hABCD, base_co2);
	endtask

	// reset, then the scenarios in order
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		sc_start();
		sc_quality();
		sc_set_base();
		end_of_test();
	end
endmodule
